// file: hw/fsr_regulator.sv
// Closed-loop fan speed regulator with tachometer counter and general pins.
`timescale 1ns/1ps
`include "fsr_cfg.svh"

module fsr_regulator #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Configuration
    input wire logic [7:0] config_bits,
    input wire logic [7:0] speed_setting,
    input wire logic [2:0] count_time,
    input wire logic [7:0] open_drive_code,
    input wire logic ext_clk_select,
    input wire logic ext_clk_pin,
    // Pin definition write port
    input wire logic pin_def_write,
    input wire logic [7:0] pin_def_data,
    output logic [7:0] pin_definition,
    // Alarms
    input wire logic [4:0] alarm_enable,
    input wire logic alarm_status_read,
    output logic [4:0] alarm_status,
    // Tachometer
    input wire logic primary_tach_input,
    output logic [7:0] tach_count,
    output logic tach_count_valid,
    // Fan drive
    output logic [7:0] fan_drive,
    output fsr_pkg::fsr_mode_t active_mode,
    // General pins, open drain
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output logic [4:0] pin_status
);

    // ============================================================
    // Input synchronisers
    localparam int SYNC_W = 7;
    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_stage1;
    logic [SYNC_W-1:0] sync_stage2;
    logic [SYNC_W-1:0] sync_delay;

    assign sync_raw = {ext_clk_pin, primary_tach_input, pin_in};

    for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (rst) begin
                sync_stage1[gi] <= 1'b1;
                sync_stage2[gi] <= 1'b1;
                sync_delay[gi] <= 1'b1;
            end else begin
                sync_stage1[gi] <= sync_raw[gi];
                sync_stage2[gi] <= sync_stage1[gi];
                sync_delay[gi] <= sync_stage2[gi];
            end
        end
    end

    logic [4:0] pin_level;
    logic tach_rise;
    logic ext_clk_rise;

    assign pin_level = sync_stage2[4:0];
    assign tach_rise = sync_stage2[5] & ~sync_delay[5];
    assign ext_clk_rise = sync_stage2[6] & ~sync_delay[6];

    // ============================================================
    // Base clock: internal oscillator divider or external edges
    localparam logic [5:0] OSC_LAST = 6'(`FSR_OSC_DIV_CYCLES - 1);
    localparam logic [6:0] BASE_LAST = 7'(`FSR_BASE_DIV - 1);
    logic [5:0] osc_count;
    logic osc_tick;
    logic clk_tick;
    logic [6:0] base_count;
    logic base_tick;

    assign osc_tick = (osc_count == OSC_LAST);
    assign clk_tick = ext_clk_select ? ext_clk_rise : osc_tick;
    assign base_tick = clk_tick && (base_count == BASE_LAST);

    always_ff @(posedge core_clk) begin
        if (rst || osc_tick) begin
            osc_count <= 6'h00;
        end else begin
            osc_count <= osc_count + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            base_count <= 7'h00;
        end else if (clk_tick) begin
            base_count <= base_count + 7'h01;
        end
    end

    // ============================================================
    // Reference divider by speed setting plus one
    logic [7:0] ref_count;
    logic ref_tick;

    assign ref_tick = base_tick && (ref_count >= speed_setting);

    always_ff @(posedge core_clk) begin
        if (rst || ref_tick) begin
            ref_count <= 8'h00;
        end else if (base_tick) begin
            ref_count <= ref_count + 8'h01;
        end
    end

    // ============================================================
    // Tachometer prescaler
    logic [2:0] prescale_sel;
    logic [3:0] prescale_mask;
    logic [3:0] prescale_count;
    logic prescale_tick;

    assign prescale_sel = config_bits[`FSR_CFG_PRESCALE_MSB:`FSR_CFG_PRESCALE_LSB];
    // Codes above the largest divider fall back to divide by 16 for stability.
    assign prescale_mask = (prescale_sel == 3'h0) ? 4'h0 :
                           (prescale_sel == 3'h1) ? 4'h1 :
                           (prescale_sel == 3'h2) ? 4'h3 :
                           (prescale_sel == 3'h3) ? 4'h7 : 4'hF;
    assign prescale_tick = tach_rise && ((prescale_count & prescale_mask) == prescale_mask);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prescale_count <= 4'h0;
        end else if (prescale_tick) begin
            prescale_count <= 4'h0;
        end else if (tach_rise) begin
            prescale_count <= prescale_count + 4'h1;
        end
    end

    // ============================================================
    // Mode selection and full-on override
    logic [1:0] mode_code;
    logic full_on_pin_mode;
    logic hw_full_on;

    assign mode_code = config_bits[`FSR_CFG_MODE_MSB:`FSR_CFG_MODE_LSB];
    assign full_on_pin_mode = (pin_definition[3:2] == `FSR_PIN_CODE_SPECIAL);
    assign hw_full_on = full_on_pin_mode && !pin_level[1];

    always_comb begin
        unique case (mode_code)
            2'h0: active_mode = fsr_pkg::fsr_mode_full_on;
            2'h1: active_mode = fsr_pkg::fsr_mode_full_off;
            2'h2: active_mode = fsr_pkg::fsr_mode_closed_loop;
            2'h3: active_mode = fsr_pkg::fsr_mode_open_loop;
        endcase
    end

    // ============================================================
    // Closed loop: compare prescaled edges against one per period
    logic [1:0] edge_tally;
    fsr_pkg::fsr_step_t loop_step;
    logic [7:0] loop_code;
    logic [7:0] next_loop_code;
    logic [7:0] next_fan_drive;
    logic loop_run;

    assign loop_run = (active_mode == fsr_pkg::fsr_mode_closed_loop);

    // Only the primary tach feeds the tally; no other tach input reaches the loop.
    always_ff @(posedge core_clk) begin
        if (rst || ref_tick) begin
            edge_tally <= 2'h0;
        end else if (prescale_tick && edge_tally != 2'h3) begin
            edge_tally <= edge_tally + 2'h1;
        end
    end

    always_comb begin
        if (edge_tally == 2'h0) begin
            loop_step = fsr_pkg::fsr_step_faster;
        end else if (edge_tally == 2'h1) begin
            loop_step = fsr_pkg::fsr_step_hold;
        end else begin
            loop_step = fsr_pkg::fsr_step_slower;
        end
    end

    // Lower code gives more fan voltage, so faster means stepping down.
    always_comb begin
        next_loop_code = loop_code;
        if (loop_step == fsr_pkg::fsr_step_faster && loop_code != `FSR_DRIVE_FULL_ON) begin
            next_loop_code = loop_code - 8'h01;
        end else if (loop_step == fsr_pkg::fsr_step_slower &&
                     loop_code != `FSR_DRIVE_FULL_OFF) begin
            next_loop_code = loop_code + 8'h01;
        end
    end

    // Outside closed loop the loop tracks the applied drive for a bumpless entry.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            loop_code <= `FSR_DRIVE_FULL_OFF;
        end else if (!loop_run || hw_full_on) begin
            loop_code <= fan_drive;
        end else if (ref_tick) begin
            loop_code <= next_loop_code;
        end
    end

    always_comb begin
        if (hw_full_on) begin
            next_fan_drive = `FSR_DRIVE_FULL_ON;
        end else begin
            unique case (active_mode)
                fsr_pkg::fsr_mode_full_on: next_fan_drive = `FSR_DRIVE_FULL_ON;
                fsr_pkg::fsr_mode_full_off: next_fan_drive = `FSR_DRIVE_FULL_OFF;
                fsr_pkg::fsr_mode_closed_loop: next_fan_drive = loop_code;
                fsr_pkg::fsr_mode_open_loop: next_fan_drive = open_drive_code;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fan_drive <= `FSR_DRIVE_FULL_OFF;
        end else begin
            fan_drive <= next_fan_drive;
        end
    end

    // ============================================================
    // Tachometer counter over a programmable interval
    logic [16:0] interval_len;
    logic [16:0] interval_count;
    logic interval_end;
    logic [7:0] pulse_count;
    logic [7:0] next_pulse_count;
    logic tach_overflow;

    assign interval_len = 17'(`FSR_TACH_BASE_TICKS) << count_time;
    assign interval_end = base_tick && (interval_count >= interval_len - 17'h00001);
    // Raw edges are counted, so the prescaler never alters this count.
    assign next_pulse_count = (pulse_count == `FSR_TACH_SAT) ? pulse_count :
                              pulse_count + 8'h01;
    assign tach_overflow = interval_end && (pulse_count == `FSR_TACH_SAT);

    always_ff @(posedge core_clk) begin
        if (rst || interval_end) begin
            interval_count <= 17'h00000;
        end else if (base_tick) begin
            interval_count <= interval_count + 17'h00001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || interval_end) begin
            pulse_count <= 8'h00;
        end else if (tach_rise) begin
            pulse_count <= next_pulse_count;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tach_count <= 8'h00;
            tach_count_valid <= 1'b0;
        end else if (interval_end) begin
            tach_count <= pulse_count;
            tach_count_valid <= 1'b1;
        end
    end

    // ============================================================
    // Alarms: sticky status, a new event wins over the read-clear
    logic [4:0] alarm_event;

    assign alarm_event[`FSR_ALARM_MIN_OUT] = loop_run && (fan_drive == `FSR_DRIVE_FULL_ON);
    assign alarm_event[`FSR_ALARM_MAX_OUT] = loop_run && (fan_drive == `FSR_DRIVE_FULL_OFF);
    assign alarm_event[`FSR_ALARM_TACH_OVF] = tach_overflow;
    assign alarm_event[`FSR_ALARM_PIN1_LOW] = !pin_level[1];
    assign alarm_event[`FSR_ALARM_PIN2_LOW] = LARGE_VARIANT && !pin_level[2];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            alarm_status <= 5'h00;
        end else if (alarm_status_read) begin
            alarm_status <= alarm_event & alarm_enable;
        end else begin
            alarm_status <= alarm_status | (alarm_event & alarm_enable);
        end
    end

    // Disabling an alarm releases the alert at once even if its status bit stays.
    logic alert_active;
    assign alert_active = |(alarm_status & alarm_enable);

    // ============================================================
    // General pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_definition <= `FSR_PIN_DEF_RESET;
        end else if (pin_def_write) begin
            pin_definition <= pin_def_data;
        end
    end

    logic [4:0] pin_present;
    logic [4:0] next_pin_oe;
    logic alert_pin_mode;

    assign pin_present = LARGE_VARIANT ? 5'h1F : 5'h03;
    assign alert_pin_mode = (pin_definition[1:0] == `FSR_PIN_CODE_SPECIAL);

    // Pin 0: alert or plain output; other codes release the pin.
    assign next_pin_oe[0] = alert_pin_mode ? alert_active :
                            (pin_definition[1:0] == `FSR_PIN_CODE_LOW);
    // Pin 1: the full-on input code leaves it released so it can be read.
    assign next_pin_oe[1] = (pin_definition[3:2] == `FSR_PIN_CODE_LOW);
    // Pin 2: the clock sharing codes are treated as released.
    assign next_pin_oe[2] = (pin_definition[5:4] == `FSR_PIN_CODE_LOW);
    assign next_pin_oe[3] = !pin_definition[6];
    assign next_pin_oe[4] = !pin_definition[7];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_oe <= 5'h00;
            pin_status <= 5'h1F;
        end else begin
            pin_oe <= next_pin_oe & pin_present;
            pin_status <= pin_level | ~pin_present;
        end
    end

    // Open drain: the pin only ever sinks, the pullup makes the high.
    assign pin_out = 5'h00;
endmodule : fsr_regulator

// file: hw/fsr_cfg.svh
// Timing counts, field positions and reset values for the fan speed regulator loop.
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// ============================================================
// Clocking
`define FSR_CORE_CLK_HZ 10000000
`define FSR_OSC_HZ 254000
`define FSR_OSC_DIV_CYCLES (`FSR_CORE_CLK_HZ / `FSR_OSC_HZ)
`define FSR_BASE_DIV 128
`define FSR_TACH_BASE_TICKS 500

// ============================================================
// Configuration field positions
`define FSR_CFG_PRESCALE_LSB 0
`define FSR_CFG_PRESCALE_MSB 2
`define FSR_CFG_MODE_LSB 4
`define FSR_CFG_MODE_MSB 5

// ============================================================
// Pin definition codes and reset value
`define FSR_PIN_CODE_LOW 2'h2
`define FSR_PIN_CODE_HIGH 2'h3
`define FSR_PIN_CODE_SPECIAL 2'h1
`define FSR_PIN_DEF_RESET 8'hFF

// ============================================================
// Alarm bit positions
`define FSR_ALARM_MIN_OUT 0
`define FSR_ALARM_MAX_OUT 1
`define FSR_ALARM_TACH_OVF 2
`define FSR_ALARM_PIN1_LOW 3
`define FSR_ALARM_PIN2_LOW 4

// ============================================================
// Drive code limits and tach count saturation
`define FSR_DRIVE_FULL_ON 8'h00
`define FSR_DRIVE_FULL_OFF 8'hFF
`define FSR_TACH_SAT 8'hFF

`endif

// file: hw/fsr_pkg.sv
// Types shared by the fan speed regulator loop.
package fsr_pkg;

    // ============================================================
    // Operating modes
    typedef enum logic [1:0] {
        fsr_mode_full_on,
        fsr_mode_full_off,
        fsr_mode_closed_loop,
        fsr_mode_open_loop
    } fsr_mode_t;

    // ============================================================
    // Loop decision per reference period
    typedef enum logic [1:0] {
        fsr_step_hold,
        fsr_step_faster,
        fsr_step_slower
    } fsr_step_t;

endpackage : fsr_pkg

// file: test/fsr_regulator_sva.sv
// Port checks of the fan speed regulator.
`timescale 1ns/1ps
module fsr_regulator_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Inputs
    input wire logic [7:0] config_bits,
    input wire logic [7:0] open_drive_code,
    input wire logic pin_def_write,
    input wire logic [7:0] pin_def_data,
    input wire logic [4:0] alarm_enable,
    input wire logic [4:0] pin_in,
    // Outputs
    input wire logic [7:0] pin_definition,
    input wire logic [4:0] alarm_status,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pin_status,
    input wire logic [7:0] fan_drive,
    input wire fsr_pkg::fsr_mode_t active_mode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ============================================================
    // Helpers
    // Pin levels need a few cycles to pass the synchronisers after reset.
    logic [2:0] settle;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            settle <= 3'h0;
        end else if (settle != 3'h7) begin
            settle <= settle + 3'h1;
        end
    end
    wire logic no_full_on = pin_definition[3:2] != 2'h1;
    wire logic in_loop = (config_bits[5:4] == 2'h2) && no_full_on;
    wire logic alert_def = pin_definition[1:0] == 2'h1;
    wire logic alert_due = |(alarm_status & alarm_enable);
    sequence s_loop_held;
        in_loop [*3];
    endsequence
    sequence s_loop_step;
        s_loop_held ##0 $changed(fan_drive);
    endsequence
    // ============================================================
    // Assertions
    a_loop_step: assert property (s_loop_step |-> fan_drive == $past(fan_drive) + 8'h01 ||
        fan_drive == $past(fan_drive) - 8'h01) else $error("loop step not one count");
    a_loop_rest: assert property (s_loop_step |=> ($stable(fan_drive) || !in_loop) [*8])
        else $error("loop stepped twice in one period");
    a_mode_on: assert property ((config_bits[5:4] == 2'h0) [*2] |-> fan_drive == 8'h00)
        else $error("full on mode drive wrong");
    a_mode_off: assert property ((config_bits[5:4] == 2'h1 && no_full_on) [*3]
        |-> fan_drive == 8'hFF) else $error("full off mode drive wrong");
    a_open_loop: assert property ((config_bits[5:4] == 2'h3 && no_full_on &&
        $stable(open_drive_code)) [*3] |-> fan_drive == open_drive_code)
        else $error("open loop drive wrong");
    a_mode_decode: assert property (active_mode == fsr_pkg::fsr_mode_t'(config_bits[5:4]))
        else $error("mode decode wrong");
    a_def_load: assert property (pin_def_write |=> pin_definition == $past(pin_def_data))
        else $error("pin definition not loaded");
    a_pin_low: assert property ((pin_definition[7] == 1'b0) [*2] |-> pin_oe[4])
        else $error("pin four not sinking");
    a_pin_released: assert property ((pin_definition[1:0] == 2'h3) [*2] |-> !pin_oe[0])
        else $error("pin zero not released");
    a_alert_follow: assert property ($past(alert_def) |-> pin_oe[0] == $past(alert_due))
        else $error("alert does not follow alarms");
    a_full_on_pin: assert property ((!no_full_on && !pin_status[1]) [*2] |->
        fan_drive == 8'h00) else $error("full on input ignored");
    a_status_sync: assert property ((settle == 3'h7 && $stable(pin_in[3])) [*4] |->
        pin_status[3] == pin_in[3]) else $error("pin status stale");
endmodule : fsr_regulator_sva

bind fsr_regulator fsr_regulator_sva fsr_regulator_sva_i (
    .core_clk(core_clk), .rst(rst), .config_bits(config_bits),
    .open_drive_code(open_drive_code), .pin_def_write(pin_def_write),
    .pin_def_data(pin_def_data), .alarm_enable(alarm_enable), .pin_in(pin_in),
    .pin_definition(pin_definition), .alarm_status(alarm_status), .pin_oe(pin_oe),
    .pin_status(pin_status), .fan_drive(fan_drive), .active_mode(active_mode)
);

// file: test/fsr_fan_model.sv
// Fan tachometer that pulses while running and rests low when stopped.
`timescale 1ns/1ps
module fsr_fan_model (
    // Clock
    input wire logic core_clk,
    // Control
    input wire logic run,
    input wire logic [15:0] half_cycles,
    // Tachometer
    output logic tach
);
    logic [15:0] count;
    always @(posedge core_clk) begin
        if (!run) begin
            tach <= 1'b0;
            count <= 16'h0000;
        end else if (count >= half_cycles - 16'h0001) begin
            tach <= ~tach;
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end
endmodule : fsr_fan_model

// file: test/fan_speed_regulator_loop_tb_top.sv
// Self-checking testbench of the fan speed regulator.
`timescale 1ns/1ps
module fan_speed_regulator_loop_tb_top;
    logic core_clk = 1'b0;
    logic rst, ext_clk_pin, pin_def_write, alarm_status_read, fan_run, tach_count_valid, tach;
    logic [7:0] config_bits, speed_setting, pin_def_data, pin_definition, tach_count, fan_drive;
    logic ext_sel;
    logic [4:0] alarm_enable, alarm_status, ext_high, pin_wire, pin_oe, pin_status, pin_out;
    fsr_pkg::fsr_mode_t active_mode;
    int miscompares = 0;
    int n_checks = 0;
    always #50 core_clk = ~core_clk;
    // Open-drain wires: any sinking party wins over the pull-up.
    always @* for (int i = 0; i < 5; i++) pin_wire[i] = ext_high[i] && (pin_oe[i] !== 1'b1);
    fsr_regulator fsr_regulator_i (
        .core_clk(core_clk), .rst(rst), .config_bits(config_bits),
        .speed_setting(speed_setting), .count_time(3'h0), .open_drive_code(8'h5A),
        .ext_clk_select(ext_sel), .ext_clk_pin(ext_clk_pin), .pin_def_write(pin_def_write),
        .pin_def_data(pin_def_data), .pin_definition(pin_definition),
        .alarm_enable(alarm_enable), .alarm_status_read(alarm_status_read),
        .alarm_status(alarm_status), .primary_tach_input(tach), .tach_count(tach_count),
        .tach_count_valid(tach_count_valid), .fan_drive(fan_drive), .active_mode(active_mode),
        .pin_in(pin_wire), .pin_out(pin_out), .pin_oe(pin_oe), .pin_status(pin_status)
    );
    fsr_fan_model fsr_fan_model_i (
        .core_clk(core_clk), .run(fan_run), .half_cycles(16'd100), .tach(tach)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic write_def(input logic [7:0] d);
        @(posedge core_clk);
        pin_def_write <= 1'b1;
        pin_def_data <= d;
        @(posedge core_clk);
        pin_def_write <= 1'b0;
        cyc(2);
    endtask : write_def
    // Counts cycles until the drive code moves; gives up after a bound.
    task automatic wait_change(output int n);
        logic [7:0] old;
        old = fan_drive;
        n = 0;
        while (fan_drive === old && n < 12000) begin
            cyc(1);
            n++;
        end
    endtask : wait_change
    task automatic t_modes();
        logic [1:0] m [3] = '{2'h0, 2'h1, 2'h3};
        logic [7:0] e [3] = '{8'h00, 8'hFF, 8'h5A};
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            config_bits <= {2'h0, m[i], 4'h0};
            cyc(3);
            check(fan_drive, e[i], "mode drive");
            check(active_mode, m[i], "mode decode");
        end
    endtask : t_modes
    task automatic t_pins();
        write_def(8'h2A);
        check(pin_oe, 5'h1F, "pins sink");
        check(pin_out, 5'h00, "sink level");
        check(pin_definition, 8'h2A, "definition");
        write_def(8'hFF);
        check(pin_oe, 5'h00, "pins released");
        @(posedge core_clk);
        ext_high <= 5'h0F;
        cyc(4);
        check(pin_status, 5'h0F, "external low");
        @(posedge core_clk);
        ext_high <= 5'h1F;
    endtask : t_pins
    task automatic t_override();
        @(posedge core_clk);
        config_bits <= 8'h10;
        alarm_enable <= 5'h08;
        write_def(8'hF5);
        @(posedge core_clk);
        ext_high <= 5'h1D;
        cyc(6);
        check(fan_drive, 8'h00, "full on wins");
        check(alarm_status, 5'h08, "alarm set");
        check(pin_oe[0], 1'b1, "alert low");
        @(posedge core_clk);
        ext_high <= 5'h1F;
        cyc(6);
        check(fan_drive, 8'hFF, "override gone");
        check(pin_oe[0], 1'b1, "alert held");
        @(posedge core_clk);
        alarm_status_read <= 1'b1;
        @(posedge core_clk);
        alarm_status_read <= 1'b0;
        cyc(3);
        check(alarm_status, 5'h00, "status cleared");
        check(pin_oe[0], 1'b0, "alert off");
        write_def(8'hFF);
    endtask : t_override
    // Steps the loop and checks direction and reference period.
    task automatic loop_step(input logic [7:0] cfg, input logic [7:0] spd, input logic run,
                             input logic [7:0] dlt, input int per);
        int n;
        logic [7:0] v;
        @(posedge core_clk);
        config_bits <= cfg;
        speed_setting <= spd;
        fan_run <= run;
        cyc(1);
        wait_change(n);
        v = fan_drive;
        wait_change(n);
        check(fan_drive, 8'(v + dlt), "loop step");
        if (per != 0) check(n, per, "reference period");
    endtask : loop_step
    task automatic t_loop();
        @(posedge core_clk);
        fan_run <= 1'b1;
        config_bits <= 8'h20;
        cyc(2500);
        check(fan_drive, 8'hFF, "top saturation");
        loop_step(8'h20, 8'h00, 1'b0, 8'hFF, 1024);
        loop_step(8'h20, 8'h01, 1'b0, 8'hFF, 2048);
        loop_step(8'h24, 8'h00, 1'b1, 8'hFF, 0);
        loop_step(8'h20, 8'h00, 1'b1, 8'h01, 1024);
        // Internal oscillator: 39 core cycles per tick, 128 ticks per base period.
        @(posedge core_clk);
        ext_sel <= 1'b0;
        loop_step(8'h20, 8'h00, 1'b0, 8'hFF, 39 * 128);
        check({tach_count_valid, tach_count}, 9'h000, "interval still running");
    endtask : t_loop
    initial begin
        ext_clk_pin = 1'b0;
        #37;
        forever #400 ext_clk_pin = ~ext_clk_pin;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        config_bits = 8'h10;
        speed_setting = 8'h00;
        pin_def_write = 1'b0;
        pin_def_data = 8'hFF;
        alarm_enable = 5'h00;
        alarm_status_read = 1'b0;
        ext_high = 5'h1F;
        fan_run = 1'b0;
        ext_sel = 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check(fan_drive, 8'hFF, "reset drive");
        check({pin_oe, pin_status}, 10'h01F, "reset pins");
        check({pin_definition, tach_count_valid}, 9'h1FE, "reset definition");
        t_modes();
        t_pins();
        t_override();
        t_loop();
        test_done();
    end
endmodule : fan_speed_regulator_loop_tb_top
